// ### core/cfg_loader_pkg.sv
package cfg_loader_pkg;
  localparam int WORD_W = 24;
  localparam int ADDR_HI = 23;
  localparam int ADDR_LO = 21;
  localparam logic [2:0] ADDR_FREQ0 = 3'h0;
  localparam logic [2:0] ADDR_FREQ1 = 3'h1;
  localparam logic [2:0] ADDR_BANK1 = 3'h5;
  localparam logic [2:0] ADDR_BANK0 = 3'h6;
  localparam logic [2:0] ADDR_TEST = 3'h7;
  localparam logic [23:0] TEST_CLEAR_WORD = 24'hE00000;
  localparam int FREQ_HI = 21;
  localparam int DEV_HI = 20;
  localparam int DEV_LO = 13;
  localparam int ACCEL_HI = 20;
  localparam int ACCEL_LO = 18;
  localparam int DIV_BIT = 17;
  localparam int MOD_BIT = 16;
  localparam int LOOP_BIT = 12;
  localparam int OSC_BIT = 11;
  localparam int AMP_HI = 10;
  localparam int AMP_LO = 9;
  localparam logic [23:0] WORD_RESET = 24'h000000;

  typedef struct packed {
    logic [21:0] freq;
    logic [1:0] amp_mode;
    logic osc_en;
    logic loop_en;
    logic mod_en;
  } bank_cfg_s;

  typedef struct packed {
    logic [7:0] fsk_dev;
    logic [2:0] acquisition_accel_code;
    logic loop_divider_select;
    logic modulation_select;
  } common_cfg_s;
endpackage

// ### core/serial_shifter.sv
`timescale 1ns/1ns
// Link-clock side: shift register clocked by the serial clock pin.
module serial_shifter (
  input wire logic i_ser_clk,
  input wire logic i_ser_data,
  output logic [23:0] o_shift
);
  typedef struct packed {
    logic [23:0] shift;
  } shifter_state_s;

  shifter_state_s state;
  shifter_state_s next_state;

  // The oldest bit falls off the top, so extra leading bits vanish.
  always_comb begin
    next_state = state;
    next_state.shift = {state.shift[22:0], i_ser_data};
  end

  // No reset: the serial clock may stand still, and a partial word is harmless.
  always_ff @(posedge i_ser_clk) begin
    state <= next_state;
  end

  assign o_shift = state.shift;

  a_shift_in: assert property (@(posedge i_ser_clk) ##1 state.shift[0] == $past(i_ser_data))
    else $error("serial bit not shifted in");
  // The register has no reset, so the whole-word check waits until 24 known bits are in.
  a_shift_order: assert property (@(posedge i_ser_clk) ##24 state.shift[23:1] == $past(state.shift[22:0]))
    else $error("shift order wrong");
endmodule

// ### core/three_wire_config_loader.sv
`timescale 1ns/1ns
module three_wire_config_loader (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_ser_clk,
  input wire logic i_ser_data,
  input wire logic i_latch_load,
  input wire logic i_bank_select,
  output logic [23:0] o_bank_zero_freq_word,
  output logic [23:0] o_bank_one_freq_word,
  output logic [23:0] o_bank_one_control_word,
  output logic [23:0] o_bank_zero_control_word,
  output logic o_test_mode,
  output cfg_loader_pkg::bank_cfg_s o_active_bank,
  output cfg_loader_pkg::common_cfg_s o_common_cfg
);
  // ----------------------------------------------------------------
  // Link side
  // ----------------------------------------------------------------
  logic [23:0] shift_word;

  serial_shifter u_shifter (
    .i_ser_clk(i_ser_clk),
    .i_ser_data(i_ser_data),
    .o_shift(shift_word)
  );

  // ----------------------------------------------------------------
  // Crossing
  // ----------------------------------------------------------------
  // The strobe is a level; the shift word is quiet while it is high, because the
  // controller keeps the serial clock low then, so sampling it on the strobe's
  // synchronised edge is a safe handshake-free word crossing.
  typedef struct packed {
    logic load_meta;
    logic load_sync;
    logic load_prev;
    logic [23:0] word_meta;
    logic [23:0] word_sync;
    logic [23:0] freq0;
    logic [23:0] freq1;
    logic [23:0] ctrl1;
    logic [23:0] ctrl0;
    logic test_mode;
  } loader_state_s;

  loader_state_s state;
  loader_state_s next_state;
  logic load_rise;
  logic [2:0] addr;

  assign load_rise = state.load_sync && !state.load_prev;
  assign addr = state.word_sync[cfg_loader_pkg::ADDR_HI:cfg_loader_pkg::ADDR_LO];

  // ----------------------------------------------------------------
  // Load decode
  // ----------------------------------------------------------------
  // Loading works regardless of any standby level, as only i_srst gates it.
  always_comb begin
    next_state = state;
    next_state.load_meta = i_latch_load;
    next_state.load_sync = state.load_meta;
    next_state.load_prev = state.load_sync;
    next_state.word_meta = shift_word;
    next_state.word_sync = state.word_meta;
    if (load_rise) begin
      if (addr == cfg_loader_pkg::ADDR_FREQ0) begin
        next_state.freq0 = {2'h0, state.word_sync[cfg_loader_pkg::FREQ_HI:0]};
      end else if (addr == cfg_loader_pkg::ADDR_FREQ1) begin
        next_state.freq1 = {2'h0, state.word_sync[cfg_loader_pkg::FREQ_HI:0]};
      end else if (addr == cfg_loader_pkg::ADDR_BANK1) begin
        next_state.ctrl1 = state.word_sync;
      end else if (addr == cfg_loader_pkg::ADDR_BANK0) begin
        next_state.ctrl0 = state.word_sync;
      end else if (addr == cfg_loader_pkg::ADDR_TEST) begin
        next_state.test_mode = (state.word_sync != cfg_loader_pkg::TEST_CLEAR_WORD);
      end
    end
    if (i_srst) begin
      next_state.load_meta = 1'b0;
      next_state.load_sync = 1'b0;
      next_state.load_prev = 1'b0;
      next_state.word_meta = cfg_loader_pkg::WORD_RESET;
      next_state.word_sync = cfg_loader_pkg::WORD_RESET;
      next_state.freq0 = cfg_loader_pkg::WORD_RESET;
      next_state.freq1 = cfg_loader_pkg::WORD_RESET;
      next_state.ctrl1 = cfg_loader_pkg::WORD_RESET;
      next_state.ctrl0 = cfg_loader_pkg::WORD_RESET;
      next_state.test_mode = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    state <= next_state;
  end

  // ----------------------------------------------------------------
  // Field outputs
  // ----------------------------------------------------------------
  logic [23:0] sel_ctrl;
  logic [23:0] sel_freq;

  // Bank choice is combinational so the pin switches banks without waiting for a clock.
  assign sel_ctrl = i_bank_select ? state.ctrl1 : state.ctrl0;
  assign sel_freq = i_bank_select ? state.freq1 : state.freq0;

  always_comb begin
    o_active_bank.freq = sel_freq[cfg_loader_pkg::FREQ_HI:0];
    o_active_bank.amp_mode = sel_ctrl[cfg_loader_pkg::AMP_HI:cfg_loader_pkg::AMP_LO];
    o_active_bank.mod_en = |sel_ctrl[cfg_loader_pkg::AMP_HI:cfg_loader_pkg::AMP_LO];
    o_active_bank.osc_en = sel_ctrl[cfg_loader_pkg::OSC_BIT];
    o_active_bank.loop_en = sel_ctrl[cfg_loader_pkg::LOOP_BIT];
    o_common_cfg.fsk_dev = state.ctrl0[cfg_loader_pkg::DEV_HI:cfg_loader_pkg::DEV_LO];
    o_common_cfg.acquisition_accel_code =
      state.ctrl1[cfg_loader_pkg::ACCEL_HI:cfg_loader_pkg::ACCEL_LO];
    o_common_cfg.loop_divider_select = state.ctrl1[cfg_loader_pkg::DIV_BIT];
    o_common_cfg.modulation_select = state.ctrl1[cfg_loader_pkg::MOD_BIT];
  end

  assign o_bank_zero_freq_word = state.freq0;
  assign o_bank_one_freq_word = state.freq1;
  assign o_bank_one_control_word = state.ctrl1;
  assign o_bank_zero_control_word = state.ctrl0;
  assign o_test_mode = state.test_mode;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_load_to_bank1;
    load_rise && addr == cfg_loader_pkg::ADDR_BANK1;
  endsequence

  a_bank1_load: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    s_load_to_bank1 |=> state.ctrl1 == $past(state.word_sync))
    else $error("bank one word not loaded");
  a_bank0_load: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    load_rise && addr == cfg_loader_pkg::ADDR_BANK0 |=> state.ctrl0 == $past(state.word_sync))
    else $error("bank zero word not loaded");
  a_latch_hold: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !load_rise |=> $stable(state.ctrl0) && $stable(state.ctrl1) && $stable(state.freq0))
    else $error("latch changed without load");
  a_test_enter: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    load_rise && addr == cfg_loader_pkg::ADDR_TEST
    && state.word_sync != cfg_loader_pkg::TEST_CLEAR_WORD |=> o_test_mode)
    else $error("test mode not entered");
  a_test_exit: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    $fell(o_test_mode) |-> $past(state.word_sync) == cfg_loader_pkg::TEST_CLEAR_WORD)
    else $error("test mode left wrongly");
  a_freq_load: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    load_rise && addr == cfg_loader_pkg::ADDR_FREQ1 |=>
    state.freq1[21:0] == $past(state.word_sync[21:0]) && state.freq1[23:22] == 2'h0)
    else $error("frequency word wrong");
  a_mod_enable: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_active_bank.mod_en == (o_active_bank.amp_mode != 2'h0))
    else $error("modulation enable mismatch");
  a_strobe_edge: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    load_rise |-> $past(i_latch_load, 2) && !$past(i_latch_load, 3))
    else $error("strobe edge missed");
  a_bank_pick: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_active_bank.loop_en == (i_bank_select ? state.ctrl1[12] : state.ctrl0[12]))
    else $error("bank select wrong");

  // ----------------------------------------------------------------
  // Checks on the crossing
  // ----------------------------------------------------------------
  // A pin edge seen by the first flop must become one load pulse two clocks on.
  sequence s_pin_rise;
    $rose(i_latch_load);
  endsequence

  sequence s_load_to_bank0;
    load_rise && addr == cfg_loader_pkg::ADDR_BANK0;
  endsequence

  sequence s_load_to_freq0;
    load_rise && addr == cfg_loader_pkg::ADDR_FREQ0;
  endsequence

  sequence s_load_to_test;
    load_rise && addr == cfg_loader_pkg::ADDR_TEST;
  endsequence

  sequence s_load_unused;
    load_rise && addr != cfg_loader_pkg::ADDR_FREQ0 && addr != cfg_loader_pkg::ADDR_FREQ1
    && addr != cfg_loader_pkg::ADDR_BANK1 && addr != cfg_loader_pkg::ADDR_BANK0
    && addr != cfg_loader_pkg::ADDR_TEST;
  endsequence

  property p_load_latency;
    @(posedge i_ref_clk) disable iff (i_srst)
    s_pin_rise |-> ##2 load_rise;
  endproperty
  a_load_latency: assert property (p_load_latency)
    else $error("load pulse late or missing");

  // The word is taken without a handshake, so it must be the one seen two clocks back.
  property p_word_cross;
    @(posedge i_ref_clk) disable iff (i_srst)
    load_rise |-> state.word_sync == $past(shift_word, 2);
  endproperty
  a_word_cross: assert property (p_word_cross)
    else $error("loaded word not the shifted word");

  // A word still moving at the load would mix bits of two frames.
  property p_word_quiet;
    @(posedge i_ref_clk) disable iff (i_srst)
    load_rise |-> $stable(state.word_sync);
  endproperty
  a_word_quiet: assert property (p_word_quiet)
    else $error("word moving at load");

  // ----------------------------------------------------------------
  // Checks on the latches
  // ----------------------------------------------------------------
  property p_freq0_load;
    @(posedge i_ref_clk) disable iff (i_srst)
    s_load_to_freq0 |=> state.freq0[21:0] == $past(state.word_sync[21:0])
    && state.freq0[23:22] == 2'h0;
  endproperty
  a_freq0_load: assert property (p_freq0_load)
    else $error("bank zero frequency wrong");

  property p_freq0_only;
    @(posedge i_ref_clk) disable iff (i_srst)
    s_load_to_freq0 |=> $stable(state.freq1) && $stable(state.ctrl0) && $stable(state.ctrl1)
    && $stable(state.test_mode);
  endproperty
  a_freq0_only: assert property (p_freq0_only)
    else $error("other latch hit by frequency load");

  property p_bank0_only;
    @(posedge i_ref_clk) disable iff (i_srst)
    s_load_to_bank0 |=> $stable(state.freq0) && $stable(state.freq1) && $stable(state.ctrl1);
  endproperty
  a_bank0_only: assert property (p_bank0_only)
    else $error("other latch hit by bank zero load");

  // Codes with no latch behind them must leave every setting alone.
  property p_unused_addr;
    @(posedge i_ref_clk) disable iff (i_srst)
    s_load_unused |=> $stable(state.freq0) && $stable(state.freq1) && $stable(state.ctrl0)
    && $stable(state.ctrl1) && $stable(state.test_mode);
  endproperty
  a_unused_addr: assert property (p_unused_addr)
    else $error("unused address changed a latch");

  property p_test_clear;
    @(posedge i_ref_clk) disable iff (i_srst)
    s_load_to_test ##0 state.word_sync == cfg_loader_pkg::TEST_CLEAR_WORD |=> !o_test_mode;
  endproperty
  a_test_clear: assert property (p_test_clear)
    else $error("test mode not cleared");

  property p_test_hold;
    @(posedge i_ref_clk) disable iff (i_srst)
    !(load_rise && addr == cfg_loader_pkg::ADDR_TEST) |=> $stable(state.test_mode);
  endproperty
  a_test_hold: assert property (p_test_hold)
    else $error("test mode moved without test load");

  property p_freq1_hold;
    @(posedge i_ref_clk) disable iff (i_srst)
    !load_rise |=> $stable(state.freq1);
  endproperty
  a_freq1_hold: assert property (p_freq1_hold)
    else $error("bank one frequency changed without load");

  // Reset stands for power-up, so every setting must come back disabled.
  property p_reset_clear;
    @(posedge i_ref_clk)
    i_srst |=> state.freq0 == cfg_loader_pkg::WORD_RESET && state.freq1 == cfg_loader_pkg::WORD_RESET
    && state.ctrl0 == cfg_loader_pkg::WORD_RESET && state.ctrl1 == cfg_loader_pkg::WORD_RESET
    && !state.test_mode;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("settings not cleared by reset");

  // ----------------------------------------------------------------
  // Checks on the field outputs
  // ----------------------------------------------------------------
  property p_freq_pick;
    @(posedge i_ref_clk) disable iff (i_srst)
    o_active_bank.freq == (i_bank_select ? state.freq1[21:0] : state.freq0[21:0]);
  endproperty
  a_freq_pick: assert property (p_freq_pick)
    else $error("active frequency from wrong bank");

  property p_amp_pick;
    @(posedge i_ref_clk) disable iff (i_srst)
    o_active_bank.amp_mode == (i_bank_select ? state.ctrl1[10:9] : state.ctrl0[10:9]);
  endproperty
  a_amp_pick: assert property (p_amp_pick)
    else $error("amplifier mode from wrong bank");

  property p_osc_pick;
    @(posedge i_ref_clk) disable iff (i_srst)
    o_active_bank.osc_en == (i_bank_select ? state.ctrl1[11] : state.ctrl0[11]);
  endproperty
  a_osc_pick: assert property (p_osc_pick)
    else $error("oscillator enable from wrong bank");

  property p_dev_field;
    @(posedge i_ref_clk) disable iff (i_srst)
    o_common_cfg.fsk_dev == state.ctrl0[20:13];
  endproperty
  a_dev_field: assert property (p_dev_field)
    else $error("deviation field wrong");

  property p_accel_field;
    @(posedge i_ref_clk) disable iff (i_srst)
    o_common_cfg.acquisition_accel_code == state.ctrl1[20:18];
  endproperty
  a_accel_field: assert property (p_accel_field)
    else $error("acceleration code wrong");

  property p_div_field;
    @(posedge i_ref_clk) disable iff (i_srst)
    o_common_cfg.loop_divider_select == state.ctrl1[17];
  endproperty
  a_div_field: assert property (p_div_field)
    else $error("loop divider select wrong");

  property p_mod_field;
    @(posedge i_ref_clk) disable iff (i_srst)
    o_common_cfg.modulation_select == state.ctrl1[16];
  endproperty
  a_mod_field: assert property (p_mod_field)
    else $error("modulation select wrong");
endmodule

// ### dv/host_ctrl_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Host controller on the three-wire port
// ----------------------------------------
module host_ctrl_model (
  output logic o_ser_clk,
  output logic o_ser_data,
  output logic o_latch_load
);
  initial begin
    o_ser_clk = 1'b0;
    o_ser_data = 1'b0;
    o_latch_load = 1'b0;
  end

  // The serial clock idles low between frames, so a stray edge never shifts.
  task automatic clk_bit(input logic b);
    o_ser_data = b;
    #15 o_ser_clk = 1'b1;
    #15 o_ser_clk = 1'b0;
  endtask

  // Leading junk bits stress the keep-last-24 behaviour of the device.
  task automatic send(input logic [23:0] w, input int extra, input bit load);
    logic [23:0] junk;
    junk = 24'($urandom());
    for (int i = extra - 1; i >= 0; i--) clk_bit(junk[i]);
    for (int i = 23; i >= 0; i--) clk_bit(w[i]);
    o_ser_data = 1'b0;
    if (load) begin
      #100 o_latch_load = 1'b1;
      #200 o_latch_load = 1'b0;
    end
    #100 o_ser_data = ~w[0];
  endtask
endmodule

// ### dv/three_wire_config_loader_tb.sv
`timescale 1ns/1ns
module three_wire_config_loader_tb;
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_bank_select = 1'b0;
  logic ser_clk, ser_data, latch_load, test_mode;
  logic [23:0] f0, f1, c1, c0;
  cfg_loader_pkg::bank_cfg_s act;
  cfg_loader_pkg::common_cfg_s com;
  logic [23:0] sh [8];
  int failures = 0;
  int compares = 0;
  int cycles = 0;

  always #10 i_ref_clk = ~i_ref_clk;

  host_ctrl_model host (.o_ser_clk(ser_clk), .o_ser_data(ser_data), .o_latch_load(latch_load));
  three_wire_config_loader dut (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_ser_clk(ser_clk), .i_ser_data(ser_data),
    .i_latch_load(latch_load), .i_bank_select(i_bank_select), .o_bank_zero_freq_word(f0),
    .o_bank_one_freq_word(f1), .o_bank_one_control_word(c1), .o_bank_zero_control_word(c0),
    .o_test_mode(test_mode), .o_active_bank(act), .o_common_cfg(com)
  );

  // ----------------------------------------
  // Expectations and checks
  // ----------------------------------------
  function automatic cfg_loader_pkg::bank_cfg_s exp_bank(input logic sel);
    logic [23:0] w;
    logic [23:0] f;
    w = sel ? sh[5] : sh[6];
    f = sel ? sh[1] : sh[0];
    return {f[21:0], w[10:9], w[11], w[12], |w[10:9]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic check_all(input logic tm);
    chk(32'(f0), 32'({2'b00, sh[0][21:0]}), "freq0");
    chk(32'(f1), 32'({2'b00, sh[1][21:0]}), "freq1");
    chk(32'(c1), 32'(sh[5]), "ctrl1");
    chk(32'(c0), 32'(sh[6]), "ctrl0");
    chk(32'(test_mode), 32'(tm), "test");
    chk(32'(com), 32'({sh[6][20:13], sh[5][20:16]}), "common");
    for (int s = 0; s < 2; s++) begin
      @(posedge i_ref_clk) #1 i_bank_select = s[0];
      #1 chk(32'(act), 32'(exp_bank(s[0])), "bank");
    end
  endtask

  task automatic load(input logic [23:0] w);
    host.send(w, $urandom_range(3), 1'b1);
    sh[w[23:21]] = w;
  endtask

  task automatic test_done();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      failures++;
      test_done();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [23:0] w;
    logic [2:0] addrs [4];
    addrs = '{3'h0, 3'h1, 3'h5, 3'h6};
    w = 24'($urandom(32'h51be));
    foreach (sh[i]) sh[i] = 24'h000000;
    repeat (3) @(posedge i_ref_clk);
    #1 i_srst = 1'b0;
    check_all(1'b0);
    load(24'hE00000);
    check_all(1'b0);
    load(24'hE00001);
    check_all(1'b1);
    load(24'hE00000);
    check_all(1'b0);
    for (int a = 0; a < 4; a++) begin
      w = 24'($urandom());
      w[23:21] = 3'h6;
      w[10:9] = a[1:0];
      load(w);
      check_all(1'b0);
    end
    for (int n = 0; n < 16; n++) begin
      w = 24'($urandom());
      w[23:21] = addrs[$urandom_range(3)];
      load(w);
      check_all(1'b0);
    end
    host.send(24'($urandom()), 0, 1'b0);
    check_all(1'b0);
    w = 24'($urandom());
    w[23:21] = 3'h2;
    host.send(w, 0, 1'b1);
    check_all(1'b0);
    load(24'hE12345);
    check_all(1'b1);
    @(posedge i_ref_clk) #1 i_srst = 1'b1;
    repeat (3) @(posedge i_ref_clk);
    #1 i_srst = 1'b0;
    foreach (sh[i]) sh[i] = 24'h000000;
    check_all(1'b0);
    test_done();
  end
endmodule
